/* File: hdl/dcl_cfg_lock.sv */
`timescale 1ns/1ps
// Contract
// RULE1: per channel gain bit in bits 9:8, one means twice gain, zero unity.
// RULE2: reference select 00 forces unity gain whatever the stored gain bit.
// RULE3: bits 6:0 of the gain and address register hold the slave address.
// RULE4: with strap pins, address is upper five stored bits plus two pins.
// RULE5: bits 15:10 and 7 of the gain and address register read zero.
// RULE6: lock bits guard volatile writes only, never nonvolatile access.
// RULE7: nonvolatile writes accepted only while high voltage enable is raised.
// RULE8: lock field 11 both, 10 wiper only, 01 config only, 00 none.
// RULE9: power-down select stays writable whatever the lock setting.
// RULE10: lock register has two bits per channel, upper bits read zero.
// RULE11: wiper value selects one of 2 to the resolution ladder taps.
// RULE12: highest wiper code is all ones, one element below reference node.
// RULE13: powered down channel has its ladder disconnected from reference.
// RULE14: power-down code 00 is normal, any other code powers down.
// RULE15: nonvolatile values load into working copies before commands serve.
module dcl_cfg_lock
   import dcl_pkg::*;
#(
   parameter int          NCH        = 2,
   parameter int          RES        = 12,
   parameter bit          HAS_STRAPS = 1'b1,
   parameter logic [15:0] NV_GA_INIT = DCL_NV_GA_RST,
   parameter logic [15:0] NV_LK_INIT = DCL_NV_LK_RST
)
(
   input  wire logic                 i_mclk,
   input  wire logic                 i_rstn,
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_rd,
   input  wire logic [4:0]           i_reg_addr,
   input  wire logic [15:0]          i_reg_wdata,
   input  wire logic                 i_high_voltage_enable_pin,
   input  wire logic                 i_addr_strap_hi,
   input  wire logic                 i_addr_strap_lo,
   input  wire logic [2*NCH-1:0]     i_reference_select,
   input  wire logic [2*NCH-1:0]     i_powerdown_select,
   output logic                      o_reg_ack,
   output logic                      o_reg_err,
   output logic [15:0]               o_reg_rdata,
   output logic                      o_ready,
   output logic [6:0]                o_slave_addr,
   output logic [NCH-1:0]            o_gain_2x,
   output logic [NCH-1:0]            o_ladder_connect,
   output logic [NCH-1:0]            o_cfg_wr_allow,
   output logic [NCH*RES-1:0]        o_tap_code
);
   localparam logic [15:0] GA_MASK =
      {6'h00, (NCH > 1), 1'b1, 1'b0, 7'h7F};
   localparam logic [15:0] LK_MASK = 16'((1 << (2 * NCH)) - 1);

   dcl_state_t        state_r;
   logic [2:0]        sync1_r;
   logic [2:0]        sync2_r;
   // store contents survive i_rstn; this value stands for the shipped cell
   logic [15:0]       nv_ga_r = NV_GA_INIT & GA_MASK;
   logic [15:0]       nv_lk_r = NV_LK_INIT & LK_MASK;
   logic [1:0]        gain_work_r;
   logic [6:0]        addr_work_r;
   logic [3:0]        lock_work_r;
   logic [NCH-1:0]    gain_2x_nxt;
   logic [NCH-1:0]    connect_nxt;
   logic [NCH-1:0]    cfg_allow_nxt;
   logic [15:0]       rdata_nxt;

   wire       hv_s      = sync2_r[2];
   wire [1:0] straps_s  = sync2_r[1:0];
   wire       running   = (state_r == DCL_ST_RUN);
   wire       req       = i_reg_wr | i_reg_rd;
   wire       sel_ga    = (i_reg_addr == DCL_ADDR_NV_GA);
   wire       sel_lk    = (i_reg_addr == DCL_ADDR_NV_LK);
   wire       sel_wp    = (i_reg_addr - DCL_ADDR_WIPER0) < 5'(NCH);
   wire       wp_ch     = i_reg_addr[0];
   // bit B of a channel field guards the wiper, bit A its config bits
   wire       wp_locked = lock_work_r[{wp_ch, 1'b1}];               // RULE8
   wire       nv_sel    = sel_ga | sel_lk;
   wire       nv_wr_ok  = running & i_reg_wr & nv_sel & hv_s;  // RULE6 RULE7
   wire       wp_wr_ok  = running & i_reg_wr & sel_wp & ~wp_locked; // RULE8
   wire       rd_ok     = running & i_reg_rd & (nv_sel | sel_wp);
   wire       req_ok    = nv_wr_ok | wp_wr_ok | rd_ok;
   wire [6:0] eff_addr  = HAS_STRAPS ?
      {addr_work_r[6:DCL_GA_STRAP_W], straps_s} : addr_work_r;     // RULE4

   always_comb
   begin
      rdata_nxt = 16'h0000;
      if (sel_ga)
         rdata_nxt = nv_ga_r & GA_MASK;                       // RULE5 RULE3
      else if (sel_lk)
         rdata_nxt = nv_lk_r & LK_MASK;                             // RULE10
      else if (sel_wp)
         rdata_nxt = 16'(o_tap_code[wp_ch*RES +: RES]);
      for (int ch = 0; ch < NCH; ch++)
      begin
         gain_2x_nxt[ch] = gain_work_r[ch] &
            (i_reference_select[2*ch +: 2] != DCL_REF_SUPPLY); // RULE1 RULE2
         // any nonzero power-down code opens the reference switch
         connect_nxt[ch] =
            (i_powerdown_select[2*ch +: 2] == DCL_PD_NORMAL); // RULE13 RULE14
         // power-down select is never covered by the config lock
         cfg_allow_nxt[ch] = ~lock_work_r[2*ch];               // RULE8 RULE9
      end
   end

   // pins cross into the clock domain before anyone looks at them
   always_ff @(posedge i_mclk)
   begin
      sync1_r <= {i_high_voltage_enable_pin, i_addr_strap_hi,
                  i_addr_strap_lo};
      sync2_r <= sync1_r;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         state_r     <= DCL_ST_LOAD;
         gain_work_r <= 2'b00;
         addr_work_r <= 7'h00;
         lock_work_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            DCL_ST_LOAD:
            begin
               // power-on copy of the store into the working config
               gain_work_r <= nv_ga_r[DCL_GA_GAIN_LSB +: 2];        // RULE15
               addr_work_r <= nv_ga_r[DCL_GA_ADDR_W-1:0];
               lock_work_r <= nv_lk_r[3:0];
               state_r     <= DCL_ST_RUN;
            end
            DCL_ST_RUN:
               state_r     <= DCL_ST_RUN;
            default:
               state_r     <= DCL_ST_LOAD;
         endcase
      end
   end

   // stored values take effect at the next power-on, as in the cell;
   // no reset here, so a write survives the reload that it waits for
   always_ff @(posedge i_mclk)
   begin
      if (i_rstn && nv_wr_ok && sel_ga)
         nv_ga_r <= i_reg_wdata & GA_MASK;                          // RULE7
      if (i_rstn && nv_wr_ok && sel_lk)
         nv_lk_r <= i_reg_wdata & LK_MASK;                          // RULE10
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         o_reg_ack        <= 1'b0;
         o_reg_err        <= 1'b0;
         o_reg_rdata      <= 16'h0000;
         o_ready          <= 1'b0;
         o_slave_addr     <= 7'h00;
         o_gain_2x        <= '0;
         o_ladder_connect <= '0;
         o_cfg_wr_allow   <= '0;
         o_tap_code       <= '0;
      end
      else
      begin
         o_reg_ack        <= req;
         o_reg_err        <= req & ~req_ok;                        // RULE15
         o_reg_rdata      <= (i_reg_rd & rd_ok) ? rdata_nxt : 16'h0000;
         o_ready          <= running;
         o_slave_addr     <= eff_addr;
         o_gain_2x        <= gain_2x_nxt;
         o_ladder_connect <= connect_nxt;
         o_cfg_wr_allow   <= running ? cfg_allow_nxt : '0;
         // full code is all ones, so no code reaches the reference node
         for (int ch = 0; ch < NCH; ch++)
            if (wp_wr_ok && wp_ch == ch[0])
               o_tap_code[ch*RES +: RES] <= i_reg_wdata[RES-1:0]; // RULE11 RULE12
      end
   end

   default clocking dcl_cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   AST_GAIN_SUPPLY: assert property (                               // RULE2
      (i_reference_select[1:0] == DCL_REF_SUPPLY) |=> !o_gain_2x[0])
      else $error("gain not forced to unity on supply reference");
   AST_GAIN_SEL: assert property (                                  // RULE1
      (i_reference_select[1:0] != DCL_REF_SUPPLY)
      |=> o_gain_2x[0] == $past(gain_work_r[0]))
      else $error("gain output does not follow stored gain bit");
   AST_ADDR: assert property (                                 // RULE3 RULE4
      running ##1 running |=> o_slave_addr[6:2] == $past(addr_work_r[6:2], 2))
      else $error("slave address upper bits wrong");
   AST_GA_ZERO: assert property (                                   // RULE5
      (i_reg_rd && sel_ga) |=> o_reg_rdata[15:10] == 6'h00
                               && !o_reg_rdata[7])
      else $error("unimplemented gain register bits not zero");
   AST_NV_HV: assert property (                                     // RULE7
      (i_reg_wr && nv_sel && !hv_s) |=> o_reg_err && $stable(nv_ga_r)
                                        && $stable(nv_lk_r))
      else $error("nonvolatile write accepted without high voltage");
   AST_NV_NOLOCK: assert property (                                 // RULE6
      (running && i_reg_wr && nv_sel && hv_s) |=> o_reg_ack && !o_reg_err)
      else $error("nonvolatile write refused by lock");
   AST_WP_LOCK: assert property (                                   // RULE8
      (i_reg_wr && sel_wp && wp_locked) |=> o_reg_err && $stable(o_tap_code))
      else $error("locked wiper was written");
   AST_CFG_LOCK: assert property (                             // RULE8 RULE9
      running |=> o_cfg_wr_allow[0] == !$past(lock_work_r[0]))
      else $error("config write allow does not follow lock bit A");
   AST_LADDER: assert property (                              // RULE13 RULE14
      (i_powerdown_select[1:0] != DCL_PD_NORMAL) |=> !o_ladder_connect[0])
      else $error("ladder connected while powered down");
   AST_LK_ZERO: assert property (                                  // RULE10
      (i_reg_rd && sel_lk) |=> (o_reg_rdata & ~LK_MASK) == 16'h0000)
      else $error("unimplemented lock bits not zero");
   AST_LOAD: assert property (                                     // RULE15
      (!running && req) |=> o_reg_err && !o_ready)
      else $error("command served before power-on load");
   AST_STRAP: assert property (                                    // RULE4
      running |=> o_slave_addr[1:0] == (HAS_STRAPS ? $past(straps_s)
                                        : $past(addr_work_r[1:0])))
      else $error("slave address low bits do not follow strap pins");
   AST_TAP_WR: assert property (                             // RULE11 RULE12
      (wp_wr_ok && !wp_ch) |=> o_tap_code[RES-1:0]
                               == $past(i_reg_wdata[RES-1:0]))
      else $error("wiper code not taken in full");
endmodule

/* File: hdl/dcl_pkg.sv */
package dcl_pkg;
   // register indices on the internal register port
   localparam logic [4:0]  DCL_ADDR_WIPER0 = 5'h00;
   localparam logic [4:0]  DCL_ADDR_NV_GA  = 5'h1A;
   localparam logic [4:0]  DCL_ADDR_NV_LK  = 5'h1B;
   // field layout of the nonvolatile gain and bus address register
   localparam int          DCL_GA_GAIN_LSB = 8;
   localparam int          DCL_GA_ADDR_W   = 7;
   localparam int          DCL_GA_STRAP_W  = 2;
   // reset values of the nonvolatile store (plain defaults)
   localparam logic [15:0] DCL_NV_GA_RST   = 16'h0060;
   localparam logic [15:0] DCL_NV_LK_RST   = 16'h0000;
   // encodings
   localparam logic [1:0]  DCL_REF_SUPPLY  = 2'b00;
   localparam logic [1:0]  DCL_PD_NORMAL   = 2'b00;
   typedef enum logic [1:0]
   {
      DCL_ST_LOAD = 2'b01,
      DCL_ST_RUN  = 2'b10
   } dcl_state_t;
endpackage

/* File: tb/dcl_host_model.sv */
`timescale 1ns/1ps
module dcl_host_model
(
   input  wire logic        i_mclk,
   output logic             o_reg_wr = 1'b0,
   output logic             o_reg_rd = 1'b0,
   output logic [4:0]       o_reg_addr = 5'h00,
   output logic [15:0]      o_reg_wdata = 16'h0000
);
   // one request pulse, then a quiet cycle before the next
   task req(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      o_reg_wr <= w;
      o_reg_rd <= !w;
      o_reg_addr <= a;
      o_reg_wdata <= d;
      @(posedge i_mclk);
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_wdata <= ~d;
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import dcl_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        hv = 1'b0;
   logic        shi = 1'b0;
   logic        slo = 1'b1;
   logic [3:0]  vref = 4'h5;
   logic [3:0]  pd = 4'h0;
   logic        wr, rd, ack, err, rdy;
   logic [4:0]  addr;
   logic [15:0] wd, rdat, r;
   logic [6:0]  sadr;
   logic [1:0]  g2, lad, cwa;
   logic [23:0] tap;
   logic [16:0] exp_q[$];
   int          bad_count = 0;
   int          n_tests = 0;
   always #12.5 i_mclk = ~i_mclk;
   dcl_host_model u_host (.i_mclk(i_mclk), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_addr(addr), .o_reg_wdata(wd));
   dcl_cfg_lock DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_high_voltage_enable_pin(hv), .i_addr_strap_hi(shi),
      .i_addr_strap_lo(slo), .i_reference_select(vref),
      .i_powerdown_select(pd), .o_reg_ack(ack), .o_reg_err(err),
      .o_reg_rdata(rdat), .o_ready(rdy), .o_slave_addr(sadr),
      .o_gain_2x(g2), .o_ladder_connect(lad), .o_cfg_wr_allow(cwa),
      .o_tap_code(tap));
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
      end
   endtask
   task chk_rsp(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
      end
   endtask
   // note the expected {err, rdata}, then issue the request
   task acc(input logic w, input logic [4:0] a, input logic [15:0] d,
            input logic [16:0] e);
      exp_q.push_back(e);
      u_host.req(w, a, d);
      repeat (2) @(negedge i_mclk);
   endtask
   // reset is low from time zero, so the opening edges count as well;
   // early puts a read on the load edge, which must be refused
   task rst(input int n, input bit early);
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      repeat (n - 1) @(posedge i_mclk);
      if (early)
         exp_q.push_back(17'h10000);
      fork
         begin
            @(posedge i_mclk);
            i_rstn <= 1'b1;
         end
         if (early)
            u_host.req(1'b0, DCL_ADDR_NV_GA, 16'h0000);
      join
      for (int k = 0; k < 20 && rdy !== 1'b1; k++)
         @(negedge i_mclk);
      if (rdy !== 1'b1)
      begin
         bad_count++;
         end_sim;
      end
   endtask
   always @(negedge i_mclk)
      if (ack === 1'b1)
         chk_rsp({err, rdat},
                 exp_q.size() ? exp_q.pop_front() : 17'h1FFFF);
   initial
   begin
      r = 16'($urandom(61508));
      @(posedge i_mclk);
      shi <= r[0];
      slo <= r[1];
      rst(10, 1'b0);
      chk(sadr, {DCL_NV_GA_RST[6:2], shi, slo});
      acc(0, DCL_ADDR_NV_GA, 0, {1'b0, DCL_NV_GA_RST & 16'h037F});
      acc(0, DCL_ADDR_NV_LK, 0, 17'h00000);
      acc(1, DCL_ADDR_NV_GA, 16'hFFFF, 17'h10000);
      acc(0, 5'h05, 0, 17'h10000);
      r = 16'($urandom);
      acc(1, DCL_ADDR_WIPER0, r, 17'h0);
      chk(tap[11:0], r[11:0]);
      acc(1, 5'h01, 16'hFFFF, 17'h0);
      chk(tap[23:12], 12'hFFF);
      @(posedge i_mclk);
      hv <= 1'b1;
      repeat (4) @(negedge i_mclk);
      acc(1, DCL_ADDR_NV_GA, 16'hFFFF, 17'h0);
      acc(0, DCL_ADDR_NV_GA, 0, 17'h0037F);
      acc(1, DCL_ADDR_NV_LK, 16'hFFFF, 17'h0);
      acc(0, DCL_ADDR_NV_LK, 0, 17'h0000F);
      @(posedge i_mclk);
      hv <= 1'b0;
      rst(3, 1'b0);
      chk(sadr, {5'h1F, shi, slo});
      chk(g2, 2'b11);
      chk(cwa, 2'b00);
      acc(1, DCL_ADDR_WIPER0, 16'h0123, 17'h10000);
      @(posedge i_mclk);
      hv <= 1'b1;
      repeat (4) @(negedge i_mclk);
      acc(1, DCL_ADDR_NV_LK, 16'h0006, 17'h0);
      @(posedge i_mclk);
      hv <= 1'b0;
      rst(3, 1'b1);
      chk(cwa, 2'b01);
      acc(1, 5'h01, 16'h0ABC, 17'h0);
      acc(1, DCL_ADDR_WIPER0, 16'h0ABC, 17'h10000);
      @(posedge i_mclk);
      vref <= 4'h1;
      for (int c = 3; c >= 0; c--)
      begin
         @(posedge i_mclk);
         pd <= {c[1:0], 2'b00};
         repeat (2) @(negedge i_mclk);
         chk(lad, {c == 0, 1'b1});
      end
      chk(g2, 2'b01);
      chk(exp_q.size(), 0);
      end_sim;
   end
endmodule
